// File: common/zcl_pkg.sv
// zcl_pkg: register map, field positions and reset values of the zero-cross control block
package zcl_pkg;

  // register indices on the 8-bit register port
  localparam logic [7:0] ZCL_ADDR_CONTROL  = 8'h00;
  localparam logic [7:0] ZCL_ADDR_INT_EN   = 8'h01;
  localparam logic [7:0] ZCL_ADDR_INT_FLAG = 8'h02;
  localparam logic [7:0] ZCL_ADDR_INT_CTRL = 8'h03;

  // control register fields
  localparam int ZCL_CON_ENABLE = 7;
  localparam int ZCL_CON_LEVEL  = 5;
  localparam int ZCL_CON_POL    = 4;
  localparam int ZCL_CON_RISE   = 1;
  localparam int ZCL_CON_FALL   = 0;

  // interrupt enable and flag registers share this bit
  localparam int ZCL_INT_BIT = 4;

  // interrupt control register fields
  localparam int ZCL_ICTL_GLOBAL = 7;
  localparam int ZCL_ICTL_GROUP  = 6;

  // reset values
  localparam logic ZCL_RST_POL      = 1'b0;
  localparam logic ZCL_RST_RISE     = 1'b0;
  localparam logic ZCL_RST_FALL     = 1'b0;
  localparam logic ZCL_RST_INT_EN   = 1'b0;
  localparam logic ZCL_RST_INT_FLAG = 1'b0;
  localparam logic ZCL_RST_GLOBAL   = 1'b0;
  localparam logic ZCL_RST_GROUP    = 1'b0;
  localparam logic [7:0] ZCL_RD_NONE = 8'h00;

  // synchroniser depth in flip-flops
  localparam int ZCL_SYNC_STAGES = 2;

endpackage

// File: logic/zcl_ctrl.sv
// zcl_ctrl: zero-cross detector control, logic output, edge interrupts and register port
//
// What this block does
// - enable set: stage active, pin taken over
// - enable clear: pin follows selection and direction
// - level bit shows sink or source by polarity
// - polarity one inverts the logic output
// - rising edge sets flag when enabled
// - falling edge sets flag when enabled
// - current stage and interrupts run in sleep
// - fuse zero: active straight out of reset
// - fuse one: inactive until software enables
// - bits 6, 3, 2 read zero, ignore writes
// - logic output offered to logic cells
// - changing polarity raises the flag
// - edge during flag clear keeps flag set
// - interrupt needs flag, enable, group, global
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
module zcl_ctrl
  import zcl_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  input  wire logic       sinkActive,
  input  wire logic       porDisableFuse,
  input  wire logic       pinSelData,
  input  wire logic       pinDirInput,
  output logic            padDataOut,
  output logic            padOe,
  output logic            currentStageEn,
  output logic            zcLogicOutput,
  output logic            zcIrq
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // one write or read strobe aimed at one register
  function automatic logic hit(input logic strobe,
                               input logic [7:0] addr,
                               input logic [7:0] target);
    hit = strobe && (addr == target);
  endfunction

  // edge qualifier: old and new sample against the wanted direction
  function automatic logic edgeSeen(input logic oldVal,
                                    input logic newVal,
                                    input logic rising);
    edgeSeen = rising ? (!oldVal && newVal) : (oldVal && !newVal);
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------

  logic       zcEnable;
  logic       zcPolarity;
  logic       zcRiseIntEn;
  logic       zcFallIntEn;
  logic       zcIntEnable;
  logic       zcIntFlag;
  logic       globalIntEn;
  logic       groupIntEn;
  logic       zcLevel;
  logic       zcLevelPrev;
  logic       sinkSync;

  // ------------------------------------------------------------------
  // decode of the register port
  // ------------------------------------------------------------------

  wire logic wrControl;
  wire logic wrIntEn;
  wire logic wrIntFlag;
  wire logic wrIntCtrl;
  wire logic rdControl;
  wire logic rdIntEn;
  wire logic rdIntFlag;
  wire logic rdIntCtrl;

  assign wrControl = hit(regWrite, regAddr, ZCL_ADDR_CONTROL);
  assign wrIntEn   = hit(regWrite, regAddr, ZCL_ADDR_INT_EN);
  assign wrIntFlag = hit(regWrite, regAddr, ZCL_ADDR_INT_FLAG);
  assign wrIntCtrl = hit(regWrite, regAddr, ZCL_ADDR_INT_CTRL);
  assign rdControl = hit(regRead, regAddr, ZCL_ADDR_CONTROL);
  assign rdIntEn   = hit(regRead, regAddr, ZCL_ADDR_INT_EN);
  assign rdIntFlag = hit(regRead, regAddr, ZCL_ADDR_INT_FLAG);
  assign rdIntCtrl = hit(regRead, regAddr, ZCL_ADDR_INT_CTRL);

  // ------------------------------------------------------------------
  // analogue indication into the clock domain
  // ------------------------------------------------------------------

  // the comparator switches at any time, so it is never used raw
  zcl_sync u_sinkSync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .asyncIn (sinkActive),
    .syncOut (sinkSync)
  );

  // ------------------------------------------------------------------
  // logic output and its edges
  // ------------------------------------------------------------------

  wire logic next_zcLevel;
  wire logic riseEdge;
  wire logic fallEdge;
  wire logic riseEvent;
  wire logic fallEvent;

  // polarity applied after the synchroniser
  assign next_zcLevel = sinkSync ^ zcPolarity;

  // edges come from successive registered samples of the output
  assign riseEdge  = edgeSeen(zcLevelPrev, zcLevel, 1'b1);
  assign fallEdge  = edgeSeen(zcLevelPrev, zcLevel, 1'b0);
  assign riseEvent = riseEdge && zcRiseIntEn;
  assign fallEvent = fallEdge && zcFallIntEn;

  // level and its previous sample have no reset; they follow the synchroniser, which reset holds low,
  // so an edge can appear after release; nothing gates them in sleep
  always_ff @(posedge ref_clk) begin
    zcLevel     <= next_zcLevel;
    zcLevelPrev <= zcLevel;
  end

  // ------------------------------------------------------------------
  // control register
  // ------------------------------------------------------------------

  wire logic polChange;
  wire logic next_zcEnable;
  wire logic next_zcPolarity;
  wire logic next_zcRiseIntEn;
  wire logic next_zcFallIntEn;

  // a write that flips polarity is an event even with the stage off
  assign polChange = wrControl && (regWdata[ZCL_CON_POL] != zcPolarity);

  // only the implemented bits take write data; 6, 5, 3, 2 are dropped
  assign next_zcEnable    = wrControl ? regWdata[ZCL_CON_ENABLE] : zcEnable;
  assign next_zcPolarity  = wrControl ? regWdata[ZCL_CON_POL]    : zcPolarity;
  assign next_zcRiseIntEn = wrControl ? regWdata[ZCL_CON_RISE]   : zcRiseIntEn;
  assign next_zcFallIntEn = wrControl ? regWdata[ZCL_CON_FALL]   : zcFallIntEn;

  // enable resets from the fuse; reset is synchronous so sampling it is safe
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      zcEnable    <= !porDisableFuse;
      zcPolarity  <= ZCL_RST_POL;
      zcRiseIntEn <= ZCL_RST_RISE;
      zcFallIntEn <= ZCL_RST_FALL;
    end else begin
      zcEnable    <= next_zcEnable;
      zcPolarity  <= next_zcPolarity;
      zcRiseIntEn <= next_zcRiseIntEn;
      zcFallIntEn <= next_zcFallIntEn;
    end
  end

  // ------------------------------------------------------------------
  // interrupt flag, enables and request
  // ------------------------------------------------------------------

  wire logic flagSet;
  wire logic flagClear;
  wire logic next_zcIntFlag;
  wire logic next_zcIntEnable;
  wire logic next_globalIntEn;
  wire logic next_groupIntEn;

  // any qualified edge or a polarity flip sets the sticky flag
  assign flagSet   = riseEvent || fallEvent || polChange;
  // write one to clear; writing zero leaves it alone
  assign flagClear = wrIntFlag && regWdata[ZCL_INT_BIT];

  // set beats clear so an edge during service is not lost
  assign next_zcIntFlag = flagSet || (zcIntFlag && !flagClear);

  assign next_zcIntEnable = wrIntEn   ? regWdata[ZCL_INT_BIT]     : zcIntEnable;
  assign next_globalIntEn = wrIntCtrl ? regWdata[ZCL_ICTL_GLOBAL] : globalIntEn;
  assign next_groupIntEn  = wrIntCtrl ? regWdata[ZCL_ICTL_GROUP]  : groupIntEn;

  // flag and enables
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      zcIntFlag   <= ZCL_RST_INT_FLAG;
      zcIntEnable <= ZCL_RST_INT_EN;
      globalIntEn <= ZCL_RST_GLOBAL;
      groupIntEn  <= ZCL_RST_GROUP;
    end else begin
      zcIntFlag   <= next_zcIntFlag;
      zcIntEnable <= next_zcIntEnable;
      globalIntEn <= next_globalIntEn;
      groupIntEn  <= next_groupIntEn;
    end
  end

  // level request: all four terms must be set
  assign zcIrq = zcIntFlag && zcIntEnable && groupIntEn && globalIntEn;

  // ------------------------------------------------------------------
  // pin ownership and outward signals
  // ------------------------------------------------------------------

  wire logic next_padOe;
  wire logic next_padDataOut;

  // enabled stage owns the pin, so the digital driver stays off
  // disabled: direction control and selected data decide
  assign next_padOe      = !zcEnable && !pinDirInput;
  assign next_padDataOut = pinSelData;

  // registered pad controls; one cycle behind their sources
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      padOe      <= 1'b0;
      padDataOut <= 1'b0;
    end else begin
      padOe      <= next_padOe;
      padDataOut <= next_padDataOut;
    end
  end

  // analogue current stage runs straight from the enable bit
  assign currentStageEn = zcEnable;

  // logic output goes to the configurable logic cells
  assign zcLogicOutput = zcLevel;

  // ------------------------------------------------------------------
  // read data, one cycle after the strobe
  // ------------------------------------------------------------------

  logic [7:0] rdControlWord;
  logic [7:0] rdIntEnWord;
  logic [7:0] rdIntFlagWord;
  logic [7:0] rdIntCtrlWord;
  logic [7:0] next_regRdata;

  // control word: unimplemented bits stay zero
  always_comb begin
    rdControlWord                 = ZCL_RD_NONE;
    rdControlWord[ZCL_CON_ENABLE] = zcEnable;
    rdControlWord[ZCL_CON_LEVEL]  = zcLevel;
    rdControlWord[ZCL_CON_POL]    = zcPolarity;
    rdControlWord[ZCL_CON_RISE]   = zcRiseIntEn;
    rdControlWord[ZCL_CON_FALL]   = zcFallIntEn;
  end

  // interrupt enable, flag and control bits sit in their documented lanes
  always_comb begin
    rdIntEnWord                   = ZCL_RD_NONE;
    rdIntEnWord[ZCL_INT_BIT]      = zcIntEnable;
    rdIntFlagWord                 = ZCL_RD_NONE;
    rdIntFlagWord[ZCL_INT_BIT]    = zcIntFlag;
    rdIntCtrlWord                 = ZCL_RD_NONE;
    rdIntCtrlWord[ZCL_ICTL_GLOBAL] = globalIntEn;
    rdIntCtrlWord[ZCL_ICTL_GROUP]  = groupIntEn;
  end

  // unmapped reads and idle cycles return zero
  assign next_regRdata = rdControl ? rdControlWord :
                         rdIntEn   ? rdIntEnWord   :
                         rdIntFlag ? rdIntFlagWord :
                         rdIntCtrl ? rdIntCtrlWord :
                                     ZCL_RD_NONE;

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      regRdata <= ZCL_RD_NONE;
    end else begin
      regRdata <= next_regRdata;
    end
  end

endmodule

// File: logic/zcl_sync.sv
// zcl_sync: two flip-flop synchroniser for the analogue sink-active level
`timescale 1ns/1ns
module zcl_sync
  import zcl_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stageOne;

  // first stage feeds only the second; nothing else may look at it
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      stageOne <= 1'b0;
      syncOut  <= 1'b0;
    end else begin
      stageOne <= asyncIn;
      syncOut  <= stageOne;
    end
  end

endmodule

// File: tb/tb.sv
// tb: self-checking bench for the zero-cross control block
`timescale 1ns/1ns
module tb
  import zcl_pkg::*;
  ;
  logic       ref_clk, nrst, regWrite, regRead, porDisableFuse;
  logic       pinSelData, pinDirInput, wantSink;
  logic [7:0] regAddr, regWdata;
  wire  [7:0] regRdata;
  wire        padDataOut, padOe, currentStageEn, zcLogicOutput, zcIrq, sinkActive;
  int         errors, n_checks, cycles;

  zcl_ctrl dut (.ref_clk, .nrst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .sinkActive, .porDisableFuse, .pinSelData, .pinDirInput, .padDataOut, .padOe,
    .currentStageEn, .zcLogicOutput, .zcIrq);
  zcl_stage_model stage (.stageEn(currentStageEn), .wantSink, .sinkActive);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  task automatic irq(input logic [7:0] a, input logic [7:0] d, input logic exp);
    wr(a, d);
    #1 chk({7'h0, zcIrq}, {7'h0, exp});
  endtask
  // one sink transition under a control setting; flag cleared first, read once settled
  task automatic step(input logic [7:0] ctl, input logic s, input logic [7:0] exp);
    wr(ZCL_ADDR_CONTROL, ctl);
    repeat (6) @(posedge ref_clk);
    wr(ZCL_ADDR_INT_FLAG, 8'h10);
    wantSink <= s;
    repeat (8) @(posedge ref_clk);
    rd(ZCL_ADDR_INT_FLAG, exp);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      results();
    end
  end

  initial begin
    {nrst, regWrite, regRead, wantSink, pinDirInput} = 5'b0;
    {porDisableFuse, pinSelData} = 2'b11;
    {regAddr, regWdata} = 16'h0;
    {errors, n_checks, cycles} = 0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(ZCL_ADDR_CONTROL, 8'h00);
    chk({6'h0, padOe, padDataOut}, 8'h03);
    wr(ZCL_ADDR_CONTROL, 8'hff);
    repeat (6) @(posedge ref_clk);
    rd(ZCL_ADDR_CONTROL, 8'hb3);
    chk({6'h0, zcLogicOutput, padOe}, 8'h02);
    rd(ZCL_ADDR_INT_FLAG, 8'h10);
    $display("test 1 done");
    step(8'h82, 1'b1, 8'h10);
    step(8'h82, 1'b0, 8'h00);
    step(8'h81, 1'b1, 8'h00);
    step(8'h81, 1'b0, 8'h10);
    wr(ZCL_ADDR_CONTROL, 8'h00);
    wr(ZCL_ADDR_INT_FLAG, 8'h10);
    wr(ZCL_ADDR_CONTROL, 8'h10);
    repeat (6) @(posedge ref_clk);
    rd(ZCL_ADDR_INT_FLAG, 8'h10);
    $display("test 2 done");
    wr(ZCL_ADDR_INT_EN, 8'h10);
    irq(ZCL_ADDR_INT_CTRL, 8'hc0, 1'b1);
    irq(ZCL_ADDR_INT_CTRL, 8'h80, 1'b0);
    irq(ZCL_ADDR_INT_CTRL, 8'h40, 1'b0);
    irq(ZCL_ADDR_INT_CTRL, 8'hc0, 1'b1);
    irq(ZCL_ADDR_INT_EN, 8'h00, 1'b0);
    irq(ZCL_ADDR_INT_EN, 8'h10, 1'b1);
    irq(ZCL_ADDR_INT_FLAG, 8'h10, 1'b0);
    wr(8'h07, 8'hff);
    rd(8'h07, 8'h00);
    rd(ZCL_ADDR_INT_CTRL, 8'hc0);
    // stage is off here, so direction and selected data alone decide the pad
    @(posedge ref_clk);
    pinDirInput <= 1'b1;
    pinSelData  <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk({6'h0, padOe, padDataOut}, 8'h00);
    $display("test 3 done");
    // clear lands on the same edge as the falling-edge event, so the event must win
    wr(ZCL_ADDR_CONTROL, 8'h91);
    repeat (4) @(posedge ref_clk);
    @(posedge ref_clk);
    wantSink <= 1'b1;
    repeat (2) @(posedge ref_clk);
    wr(ZCL_ADDR_INT_FLAG, 8'h10);
    rd(ZCL_ADDR_INT_FLAG, 8'h10);
    chk({7'h0, zcIrq}, 8'h01);
    $display("test 4 done");
    @(posedge ref_clk);
    nrst           <= 1'b0;
    porDisableFuse <= 1'b0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(ZCL_ADDR_CONTROL, 8'ha0);
    rd(ZCL_ADDR_INT_FLAG, 8'h00);
    chk({6'h0, currentStageEn, padOe}, 8'h02);
    $display("test 5 done");
    results();
  end
endmodule

// File: tb/zcl_ctrl_assertions.sv
// zcl_ctrl_assertions: port-level checks of the zero-cross control block
`timescale 1ns/1ns
module zcl_ctrl_assertions
  import zcl_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       sinkActive,
  input wire logic       porDisableFuse,
  input wire logic       pinSelData,
  input wire logic       pinDirInput,
  input wire logic       padDataOut,
  input wire logic       padOe,
  input wire logic       currentStageEn,
  input wire logic       zcLogicOutput,
  input wire logic       zcIrq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // decoded strobes, named so the properties stay short
  wire ctlWr = regWrite && regAddr == ZCL_ADDR_CONTROL;
  wire ctlRd = regRead && regAddr == ZCL_ADDR_CONTROL;

  a_read_idle_zero: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data not zero outside a read");
  a_reserved_zero: assert property (ctlRd |=> regRdata[6] == 1'b0 && regRdata[3:2] == 2'b00)
    else $error("unimplemented control bits read nonzero");
  a_level_bit: assert property (ctlRd |=> regRdata[ZCL_CON_LEVEL] == $past(zcLogicOutput))
    else $error("level bit differs from logic output");
  a_stage_follows: assert property (ctlWr |=> currentStageEn == $past(regWdata[ZCL_CON_ENABLE]))
    else $error("current stage does not follow enable write");
  // pad is only ours when the detector is off and direction says output
  a_pad_oe: assert property ($past(nrst) |-> padOe == $past(!currentStageEn && !pinDirInput))
    else $error("pad enable wrong for enable and direction");
  a_pad_data: assert property ($past(nrst) |-> padDataOut == $past(pinSelData))
    else $error("pad data does not follow pin selection");
  a_irq_global_off: assert property (regWrite && regAddr == ZCL_ADDR_INT_CTRL
    && !regWdata[ZCL_ICTL_GLOBAL] |=> !zcIrq)
    else $error("interrupt with global enable off");
  a_irq_mask_off: assert property (regWrite && regAddr == ZCL_ADDR_INT_EN
    && !regWdata[ZCL_INT_BIT] |=> !zcIrq)
    else $error("interrupt with its enable off");
  a_irq_sticky: assert property (zcIrq && !regWrite |=> zcIrq)
    else $error("interrupt dropped without a write");
  // checked while reset is held, so reset must not disable it
  a_fuse_reset: assert property (disable iff (1'b0)
    !nrst && $past(!nrst) |-> currentStageEn == !$past(porDisableFuse))
    else $error("enable reset value does not follow fuse");

  c_irq_rise: cover property ($rose(zcIrq));
  c_pol_write: cover property (ctlWr && regWdata[ZCL_CON_POL]);
  c_fuse_active: cover property (disable iff (1'b0) !nrst && !porDisableFuse);
endmodule

bind zcl_ctrl zcl_ctrl_assertions u_chk (.ref_clk, .nrst, .regAddr, .regWdata, .regWrite,
  .regRead, .regRdata, .sinkActive, .porDisableFuse, .pinSelData, .pinDirInput,
  .padDataOut, .padOe, .currentStageEn, .zcLogicOutput, .zcIrq);

// File: tb/zcl_stage_model.sv
// zcl_stage_model: behavioural analogue current stage feeding the sink indication
`timescale 1ns/1ns
module zcl_stage_model (
  input  wire logic stageEn,
  input  wire logic wantSink,
  output wire logic sinkActive
);
  // a stage that is off neither sinks nor sources; the delay keeps it off the clock edge
  assign #1 sinkActive = stageEn && wantSink;
endmodule
